/* dv/sdmc_tb.sv */
// bench for the converter mode control block: apb driver, transfer monitor, checks
// assumes sdmc_params.svh and sdmc_pkg are compiled before this file
`include "sdmc_params.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sdmc_pkg::*;
   // ==========================================
   // signals
   localparam logic [7:0] mode_a = `SDMC_MODE_OFS;
   localparam logic [7:0] decim_a = `SDMC_DECIM_OFS;
   localparam logic [7:0] stat_a = `SDMC_STAT_OFS;
   localparam logic [7:0] mask_a = `SDMC_MASK_OFS;
   localparam logic [7:0] res0_a = `SDMC_RES0_OFS;
   localparam logic [7:0] res1_a = `SDMC_RES1_OFS;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   sdmc_apb_req_type apb_req = '0;
   sdmc_apb_rsp_type apb_rsp;
   logic [23:0] primary_sample = 24'h0;
   logic [23:0] auxiliary_sample = 24'h0;
   sdmc_ana_type ana;
   logic irq;
   int mismatches = 0;
   int comparisons = 0;
   logic [31:0] seed = 32'hBB51;
   logic [33:0] notes[$];
   logic [33:0] note;
   logic [23:0] s0;
   logic [23:0] s1;
   logic [23:0] old0;
   logic [23:0] old1;
   always #12.5 pclk = ~pclk;
   // one modulator tick per pclk keeps conversions short
   sdmc_mode_ctrl #(.MOD_DIV(1)) u_sdmc_mode_ctrl (
      .pclk(pclk),
      .presetn(presetn),
      .apb_req(apb_req),
      .apb_rsp(apb_rsp),
      .primary_sample(primary_sample),
      .auxiliary_sample(auxiliary_sample),
      .ana(ana),
      .irq(irq)
   );
   // ==========================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic err, input logic [31:0] exp);
      int n;
      notes.push_back({~w, err, exp});
      @(posedge pclk);
      apb_req.psel <= 1'b1;
      apb_req.pwrite <= w;
      apb_req.paddr <= a;
      apb_req.pwdata <= d;
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 100);
      if (apb_rsp.pready !== 1'b1) begin
         chk("pready", 32'h1, {31'h0, apb_rsp.pready});
         complete_run();
      end
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 1'b0, exp);
   endtask
   // registered outputs are checked two edges past the write edge
   task automatic settle();
      repeat (2) @(posedge pclk);
      #1;
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         @(posedge pclk);
         #1;
         n++;
      end
      if (irq !== 1'b1) begin
         chk("irq", 32'h1, {31'h0, irq});
         complete_run();
      end
   endtask
   task automatic new_samples();
      @(posedge pclk);
      seed = lfsr(seed);
      s0 = seed[23:0];
      seed = lfsr(seed);
      s1 = seed[23:0];
      primary_sample <= s0;
      auxiliary_sample <= s1;
   endtask
   // ==========================================
   // monitor: oldest note against each completed transfer
   always @(posedge pclk) begin
      if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1) begin
         note = notes.pop_front();
         chk("pslverr", {31'h0, note[32]}, {31'h0, apb_rsp.pslverr});
         if (note[33]) begin
            chk("prdata", note[31:0], apb_rsp.prdata);
         end
      end
   end
   // ==========================================
   // scenarios
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      chk("filt_rst", 32'h1, {31'h0, ana.filt_rst});
      chk("chop_on", 32'h0, {31'h0, ana.chop_on});
      rd(mode_a, 32'h08);
      rd(decim_a, 32'h45);
      wr(mode_a, 32'h29);
      settle();
      chk("pwr", 32'h2, {30'h0, ana.pwr0, ana.pwr1});
      chk("idle", 32'h3, {30'h0, ana.mod_clk_en, ana.filt_rst});
      wr(mode_a, 32'h19);
      settle();
      chk("pwr", 32'h1, {30'h0, ana.pwr0, ana.pwr1});
      wr(mode_a, 32'h08);
      settle();
      chk("pwr", 32'h0, {29'h0, ana.pwr0, ana.pwr1, ana.mod_clk_en});
      // single conversion on both converters, chop off, shortest word
      wr(decim_a, 32'h3);
      wr(mask_a, 32'h3);
      new_samples();
      wr(mode_a, 32'h3A);
      settle();
      chk("decim_eff", 32'h3, {24'h0, ana.decim_eff});
      wait_irq();
      rd(res0_a, {8'h0, s0});
      rd(res1_a, {8'h0, s1});
      rd(mode_a, 32'h38);
      rd(stat_a, 32'h3);
      wr(mask_a, 32'h0);
      settle();
      chk("irq", 32'h0, {31'h0, irq});
      wr(mask_a, 32'h3);
      settle();
      chk("irq", 32'h1, {31'h0, irq});
      wr(stat_a, 32'h3);
      settle();
      chk("irq", 32'h0, {31'h0, irq});
      // continuous on the primary only: primary result keeps refreshing, auxiliary result holds
      wr(mask_a, 32'h1);
      wr(mode_a, 32'h2B);
      wait_irq();
      old0 = s0;
      old1 = s1;
      new_samples();
      rd(res0_a, {8'h0, old0});
      wr(stat_a, 32'h1);
      settle();
      wait_irq();
      rd(res0_a, {8'h0, s0});
      rd(res1_a, {8'h0, old1});
      rd(mode_a, 32'h2B);
      wr(mode_a, 32'h28);
      // every calibration code, chop on, both converters
      wr(mask_a, 32'h4);
      for (int m = 4; m < 8; m++) begin
         wr(mode_a, 32'(32'h30 + m));
         settle();
         chk("cal_path", 32'h8 >> (m - 4),
             {28'h0, ana.short_in, ana.ref_in, ana.sys_zero, ana.sys_full});
         chk("chop_on", 32'h1, {31'h0, ana.chop_on});
         wait_irq();
         rd(mode_a, 32'h31);
         wr(stat_a, 32'h4);
         settle();
      end
      // notch, unimplemented bit, refusals
      wr(decim_a, 32'h45);
      wr(mask_a, 32'h8);
      wr(stat_a, 32'hF);
      wr(mode_a, 32'hC8);
      settle();
      chk("notch", 32'h1, {31'h0, ana.notch});
      chk("irq", 32'h0, {31'h0, irq});
      rd(mode_a, 32'h48);
      wr(decim_a, 32'h43);
      settle();
      chk("irq", 32'h1, {31'h0, irq});
      rd(stat_a, 32'h8);
      rd(decim_a, 32'h43);
      apb(1'b0, 8'h20, 32'h0, 1'b1, 32'h0);
      apb(1'b1, 8'h20, 32'h5, 1'b1, 32'h0);
      wr(res0_a, 32'hFF);
      rd(res0_a, {8'h0, s0});
      complete_run();
   end
endmodule
`default_nettype wire

/* logic/sdmc_conv_timer.sv */
// conversion timer: one done pulse per filter output period
// assumes run and restart come from logic on pclk
`include "sdmc_params.svh"
`default_nettype none
module sdmc_conv_timer #(
   parameter int unsigned MOD_DIV = `SDMC_MOD_DIV
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic run,
   input wire logic restart,
   input wire logic chop_on,
   input wire logic [7:0] sf,
   // event
   output logic done
);
   import sdmc_pkg::*;
   sdmc_tmr_type s_q, s_d;
   logic [12:0] len;
   // ==========================================
   // period: 8 modulator clocks per sf step, three times that with chop
   always_comb begin
      len = 13'(sf) * (chop_on ? `SDMC_TICKS_CHOP_ON : `SDMC_TICKS_CHOP_OFF);
      s_d = s_q;
      s_d.done = 1'b0;
      if (!run || restart) begin
         s_d.div = 16'h0000;
         s_d.tick = 13'h0000;
      end else if (s_q.div == 16'(MOD_DIV - 1)) begin
         s_d.div = 16'h0000;
         if (s_q.tick == len - 13'h0001) begin
            s_d.tick = 13'h0000;
            s_d.done = 1'b1;
         end else begin
            s_d.tick = s_q.tick + 13'h0001;
         end
      end else begin
         s_d.div = s_q.div + 16'h0001;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) s_q <= '0;
      else s_q <= s_d;
   end
   assign done = s_q.done;
endmodule
`default_nettype wire

/* logic/sdmc_evt.sv */
// sticky event flags, write-one-to-clear, with mask and one level interrupt
// assumes set, clr and mask_we come from logic on pclk
`default_nettype none
module sdmc_evt (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // events and software access
   input wire logic [3:0] set,
   input wire logic [3:0] clr,
   input wire logic mask_we,
   input wire logic [3:0] mask_wdata,
   // state
   output logic [3:0] status,
   output logic [3:0] mask,
   output logic irq
);
   import sdmc_pkg::*;
   sdmc_evt_type s_q, s_d;
   // ==========================================
   // set beats clear so no event is lost
   always_comb begin
      s_d = s_q;
      s_d.status = (s_q.status & ~clr) | set;
      if (mask_we) s_d.mask = mask_wdata;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) s_q <= '0;
      else s_q <= s_d;
   end
   assign status = s_q.status;
   assign mask = s_q.mask;
   assign irq = |(s_q.status & s_q.mask);
endmodule
`default_nettype wire

/* logic/sdmc_mode_ctrl.sv */
// converter mode control: mode register, decimation word, results, events
// assumes an APB master on pclk and filter samples valid on pclk
//
// The APB register port and the placing of the registers were decided locally.
`include "sdmc_params.svh"
`default_nettype none
module sdmc_mode_ctrl #(
   parameter int unsigned MOD_DIV = `SDMC_MOD_DIV
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // register bus
   input wire sdmc_pkg::sdmc_apb_req_type apb_req,
   output sdmc_pkg::sdmc_apb_rsp_type apb_rsp,
   // filter outputs
   input wire logic [23:0] primary_sample,
   input wire logic [23:0] auxiliary_sample,
   // converter control
   output sdmc_pkg::sdmc_ana_type ana,
   output logic irq
);
   import sdmc_pkg::*;

   sdmc_top_type s_q, s_d;
   sdmc_ctrl_type wctrl;
   logic setup;
   logic wr;
   logic wr_mode;
   logic wr_decim;
   logic wr_stat;
   logic wr_mask;
   logic done;
   logic notch_evt;
   logic [3:0] ev_set;
   logic [3:0] ev_clr;
   logic [3:0] status;
   logic [3:0] mask;
   logic [31:0] rd;
   logic [7:0] wbyte;

   // ==========================================
   // helpers
   function automatic logic sdmc_hit(input logic [7:0] a);
      return a == `SDMC_MODE_OFS || a == `SDMC_DECIM_OFS ||
         a == `SDMC_STAT_OFS || a == `SDMC_MASK_OFS ||
         a == `SDMC_RES0_OFS || a == `SDMC_RES1_OFS;
   endfunction

   // low words would stall the filter, so they are raised to the floor
   function automatic logic [7:0] sdmc_clamp(input logic [7:0] sf,
                                             input logic chop_dis);
      logic [7:0] lo;
      lo = chop_dis ? `SDMC_SF_MIN_CHOP_OFF : `SDMC_SF_MIN_CHOP_ON;
      return (sf < lo) ? lo : sf;
   endfunction

   // ==========================================
   // bus decode
   assign setup = apb_req.psel & ~apb_req.penable;
   assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign wbyte = apb_req.pwdata[7:0];
   assign wr_mode = wr && apb_req.paddr == `SDMC_MODE_OFS;
   assign wr_decim = wr && apb_req.paddr == `SDMC_DECIM_OFS;
   assign wr_stat = wr && apb_req.paddr == `SDMC_STAT_OFS;
   assign wr_mask = wr && apb_req.paddr == `SDMC_MASK_OFS;
   // bit 7 never stored
   assign wctrl = sdmc_ctrl_type'(wbyte & `SDMC_MODE_WMASK);

   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = apb_req.psel & apb_req.penable &
      ~sdmc_hit(apb_req.paddr);
   assign apb_rsp.prdata = s_q.prdata;

   always_comb begin
      rd = 32'h0000_0000;
      unique case (apb_req.paddr)
         `SDMC_MODE_OFS: rd[7:0] = s_q.ctrl;
         `SDMC_DECIM_OFS: rd[7:0] = s_q.decim;
         `SDMC_STAT_OFS: rd[3:0] = status;
         `SDMC_MASK_OFS: rd[3:0] = mask;
         `SDMC_RES0_OFS: rd[23:0] = s_q.res0;
         `SDMC_RES1_OFS: rd[23:0] = s_q.res1;
         default: rd = 32'h0000_0000;
      endcase
   end

   // ==========================================
   // events
   // notch below the floor is software's error; flagged, not blocked
   assign notch_evt = (wr_mode && wctrl.notch &&
      s_q.decim < `SDMC_NOTCH_MIN_SF) ||
      (wr_decim && s_q.ctrl.notch && wbyte < `SDMC_NOTCH_MIN_SF);

   always_comb begin
      ev_set = 4'h0;
      if (done && s_q.st == ST_RUN) begin
         if (s_q.ctrl.mode == `SDMC_MD_SINGLE ||
             s_q.ctrl.mode == `SDMC_MD_CONT) begin
            ev_set[`SDMC_ST_RDY0] = s_q.ctrl.en0;
            ev_set[`SDMC_ST_RDY1] = s_q.ctrl.en1;
         end else begin
            ev_set[`SDMC_ST_CAL] = 1'b1;
         end
      end
      ev_set[`SDMC_ST_NOTCH] = notch_evt;
   end
   assign ev_clr = wr_stat ? wbyte[3:0] : 4'h0;

   // ==========================================
   // next state
   always_comb begin
      s_d = s_q;
      s_d.restart = wr_mode;
      if (setup) s_d.prdata = rd;
      // finished conversion
      if (done && s_q.st == ST_RUN) begin
         unique case (s_q.ctrl.mode)
            `SDMC_MD_SINGLE: begin
               if (s_q.ctrl.en0) s_d.res0 = primary_sample;
               if (s_q.ctrl.en1) s_d.res1 = auxiliary_sample;
               s_d.ctrl.mode = `SDMC_MD_OFF;
            end
            `SDMC_MD_CONT: begin
               if (s_q.ctrl.en0) s_d.res0 = primary_sample;
               if (s_q.ctrl.en1) s_d.res1 = auxiliary_sample;
            end
            // calibration ends parked in idle, ready to convert
            default: s_d.ctrl.mode = `SDMC_MD_IDLE;
         endcase
      end
      // software write wins over the hardware mode return
      if (wr_mode) s_d.ctrl = wctrl;
      if (wr_decim) s_d.decim = wbyte;
      // mode field picks the state of the enabled converters
      if (!(s_d.ctrl.en0 || s_d.ctrl.en1) ||
          s_d.ctrl.mode == `SDMC_MD_OFF) begin
         s_d.st = ST_OFF;
      end else if (s_d.ctrl.mode == `SDMC_MD_IDLE) begin
         s_d.st = ST_IDLE;
      end else begin
         s_d.st = ST_RUN;
      end
      // analog controls follow the next register value
      s_d.ana.pwr0 = s_d.ctrl.en0 && s_d.ctrl.mode != `SDMC_MD_OFF;
      s_d.ana.pwr1 = s_d.ctrl.en1 && s_d.ctrl.mode != `SDMC_MD_OFF;
      s_d.ana.mod_clk_en = s_d.st != ST_OFF;
      s_d.ana.filt_rst = s_d.st != ST_RUN;
      s_d.ana.chop_on = ~s_d.ctrl.chop_dis;
      s_d.ana.notch = s_d.ctrl.notch;
      s_d.ana.short_in = s_d.st == ST_RUN &&
         s_d.ctrl.mode == `SDMC_MD_ZS_INT;
      s_d.ana.ref_in = s_d.st == ST_RUN &&
         s_d.ctrl.mode == `SDMC_MD_FS_INT;
      s_d.ana.sys_zero = s_d.st == ST_RUN &&
         s_d.ctrl.mode == `SDMC_MD_ZS_SYS;
      s_d.ana.sys_full = s_d.st == ST_RUN &&
         s_d.ctrl.mode == `SDMC_MD_FS_SYS;
      s_d.ana.decim_eff = sdmc_clamp(s_d.decim, s_d.ctrl.chop_dis);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.ctrl <= sdmc_ctrl_type'(`SDMC_MODE_RST);
         s_q.decim <= `SDMC_DECIM_RST;
         s_q.st <= ST_OFF;
         s_q.ana.filt_rst <= 1'b1;
         s_q.ana.decim_eff <= `SDMC_DECIM_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign ana = s_q.ana;

   // ==========================================
   // submodules
   sdmc_conv_timer #(
      .MOD_DIV(MOD_DIV)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .run(s_q.st == ST_RUN),
      .restart(s_q.restart),
      .chop_on(s_q.ana.chop_on),
      .sf(s_q.ana.decim_eff),
      .done(done)
   );

   sdmc_evt u_evt (
      .pclk(pclk),
      .presetn(presetn),
      .set(ev_set),
      .clr(ev_clr),
      .mask_we(wr_mask),
      .mask_wdata(wbyte[3:0]),
      .status(status),
      .mask(mask),
      .irq(irq)
   );

   // ==========================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_single_returns_off: assert property (
      done && s_q.st == ST_RUN && s_q.ctrl.mode == `SDMC_MD_SINGLE
      && !wr_mode |=> s_q.ctrl.mode == `SDMC_MD_OFF && s_q.st == ST_OFF)
      else $error("single conversion did not return to power-down");

   a_single_flags: assert property (
      done && s_q.st == ST_RUN && s_q.ctrl.mode == `SDMC_MD_SINGLE
      && s_q.ctrl.en0 |=> ##1 status[`SDMC_ST_RDY0])
      else $error("single conversion left ready flag clear");

   a_cont_keeps: assert property (
      done && s_q.st == ST_RUN && s_q.ctrl.mode == `SDMC_MD_CONT
      && !wr_mode |=> s_q.ctrl.mode == `SDMC_MD_CONT
      && s_q.res0 == $past(s_q.ctrl.en0 ? primary_sample : s_q.res0))
      else $error("continuous conversion lost mode or result");

   a_results_hold: assert property (
      !done |=> $stable(s_q.res0) && $stable(s_q.res1))
      else $error("result changed without a conversion");

   a_primary_power: assert property (
      wr_mode |=> ana.pwr0 == $past(wctrl.en0 && wctrl.mode != `SDMC_MD_OFF)
      ) else $error("primary power does not follow enable");

   a_aux_power: assert property (
      wr_mode && !wctrl.en1 |=> !ana.pwr1 [*2])
      else $error("auxiliary powered while disabled");

   a_chop_both: assert property (
      wr_mode |=> ana.chop_on == !$past(wbyte[3]))
      else $error("chop control does not follow chop disable bit");

   a_bit7_ignored: assert property (
      s_q.ctrl.spare == 1'b0)
      else $error("unimplemented mode bit stored");

   a_idle_state: assert property (
      s_q.st == ST_IDLE |-> ana.filt_rst && ana.mod_clk_en)
      else $error("idle without filter reset or clocks");

   a_int_cal_switch: assert property (
      wr_mode && (wctrl.en0 || wctrl.en1) && wctrl.mode == `SDMC_MD_ZS_INT
      |=> ana.short_in && !ana.ref_in)
      else $error("zero-scale calibration without input short");

   a_fs_cal_ref: assert property (
      ana.ref_in |-> s_q.ctrl.mode == `SDMC_MD_FS_INT && !ana.filt_rst)
      else $error("reference switched outside full-scale calibration");

   a_sf_floor: assert property (
      ana.decim_eff >= `SDMC_SF_MIN_CHOP_OFF &&
      (ana.chop_on -> ana.decim_eff >= `SDMC_SF_MIN_CHOP_ON))
      else $error("decimation below the floor");

   a_notch_follow: assert property (
      wr_mode |=> ana.notch == $past(wbyte[6]))
      else $error("notch does not follow its select bit");

   a_reset_off: assert property (
      $rose(presetn) |-> s_q.ctrl.mode == `SDMC_MD_OFF)
      else $error("mode field not power-down after reset");

   c_single: cover property (
      done && s_q.ctrl.mode == `SDMC_MD_SINGLE ##1 s_q.st == ST_OFF);
   c_cont_two: cover property (
      done && s_q.ctrl.mode == `SDMC_MD_CONT ##[1:1000] done);
   c_cal_done: cover property (
      ev_set[`SDMC_ST_CAL] ##1 irq);
   c_notch_err: cover property (notch_evt);
endmodule
`default_nettype wire

/* logic/sdmc_params.svh */
// constants of the converter mode control block: offsets, fields, resets, timing
// assumes a 40 MHz pclk and a 32.768 kHz modulator clock
`ifndef SDMC_PARAMS_SVH
`define SDMC_PARAMS_SVH
// ==========================================
// register byte offsets
`define SDMC_MODE_OFS 8'h00
`define SDMC_DECIM_OFS 8'h04
`define SDMC_STAT_OFS 8'h08
`define SDMC_MASK_OFS 8'h0C
`define SDMC_RES0_OFS 8'h10
`define SDMC_RES1_OFS 8'h14
// ==========================================
// reset values and masks
`define SDMC_MODE_RST 8'h08
`define SDMC_DECIM_RST 8'h45
`define SDMC_MODE_WMASK 8'h7F
// ==========================================
// mode field codes
`define SDMC_MD_OFF 3'h0
`define SDMC_MD_IDLE 3'h1
`define SDMC_MD_SINGLE 3'h2
`define SDMC_MD_CONT 3'h3
`define SDMC_MD_ZS_INT 3'h4
`define SDMC_MD_FS_INT 3'h5
`define SDMC_MD_ZS_SYS 3'h6
`define SDMC_MD_FS_SYS 3'h7
// ==========================================
// status bit positions
`define SDMC_ST_RDY0 0
`define SDMC_ST_RDY1 1
`define SDMC_ST_CAL 2
`define SDMC_ST_NOTCH 3
// ==========================================
// decimation limits and timing
`define SDMC_NOTCH_MIN_SF 8'h44
`define SDMC_SF_MIN_CHOP_OFF 8'h03
`define SDMC_SF_MIN_CHOP_ON 8'h0D
`define SDMC_TICKS_CHOP_OFF 13'h0008
`define SDMC_TICKS_CHOP_ON 13'h0018
`define SDMC_PCLK_HZ 40000000
`define SDMC_MOD_HZ 32768
`define SDMC_MOD_DIV (`SDMC_PCLK_HZ / `SDMC_MOD_HZ)
`endif

/* logic/sdmc_pkg.sv */
// types of the converter mode control block
// assumes sdmc_params.svh for all numbers
`default_nettype none
package sdmc_pkg;
   typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_RUN} sdmc_state_type;
   typedef struct packed {
      logic spare;
      logic notch;
      logic en0;
      logic en1;
      logic chop_dis;
      logic [2:0] mode;
   } sdmc_ctrl_type;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } sdmc_apb_req_type;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } sdmc_apb_rsp_type;
   typedef struct packed {
      logic pwr0;
      logic pwr1;
      logic mod_clk_en;
      logic filt_rst;
      logic chop_on;
      logic notch;
      logic short_in;
      logic ref_in;
      logic sys_zero;
      logic sys_full;
      logic [7:0] decim_eff;
   } sdmc_ana_type;
   typedef struct packed {
      logic [15:0] div;
      logic [12:0] tick;
      logic done;
   } sdmc_tmr_type;
   typedef struct packed {
      logic [3:0] status;
      logic [3:0] mask;
   } sdmc_evt_type;
   typedef struct packed {
      sdmc_ctrl_type ctrl;
      logic [7:0] decim;
      logic [23:0] res0;
      logic [23:0] res1;
      logic [31:0] prdata;
      logic restart;
      sdmc_state_type st;
      sdmc_ana_type ana;
   } sdmc_top_type;
endpackage
`default_nettype wire
